// ---- group_level_cfg.svh ----
// constants of the second and third group current level registers
// assumes a byte-wide address and a six-bit data word from the pulse decoder
`ifndef GROUP_LEVEL_CFG_SVH
`define GROUP_LEVEL_CFG_SVH

`define SINK_COUNT        5
`define ADDR_WIDTH        8
`define DATA_WIDTH        6
`define CODE_WIDTH        5
`define CURRENT_WIDTH     6

`define SECOND_LEVEL_ADDR 8'h02
`define THIRD_LEVEL_ADDR  8'h03
`define LEVEL_RESET       5'h00
`define CODE_MSB          4

`define CODE_FIRST_STEP   5'h04
`define CODE_FINE_LAST    5'h0d
`define CODE_SIX_MA       5'h0e
`define CODE_SEVEN_MA     5'h0f
`define CODE_COARSE_LAST  5'h1d
`define CODE_23_MA        5'h1e
`define CODE_25_MA        5'h1f
`define FINE_OFFSET       5'h03
`define COARSE_OFFSET     5'h08

`define CURRENT_ZERO      6'h00
`define CURRENT_6_MA      6'h0c
`define CURRENT_7_MA      6'h0e
`define CURRENT_23_MA     6'h2e
`define CURRENT_25_MA     6'h32

`endif

// ---- group_level_pkg.sv ----
// types of the second and third group current level block
// assumes group_level_cfg.svh is on the include path
`include "group_level_cfg.svh"

package group_level_pkg;

    typedef logic [`CODE_WIDTH-1:0]    level_code_t;
    typedef logic [`CURRENT_WIDTH-1:0] half_ma_t;

    typedef struct packed {
        level_code_t                   second_code;
        level_code_t                   third_code;
        logic [`SINK_COUNT-1:0]        sink_act;
        half_ma_t [`SINK_COUNT-1:0]    sink_cur;
    } level_state_t;

endpackage

// ---- level_if.sv ----
// carrier between the level registers and the level decoder
// assumes one level register per instance
`timescale 1ns/100ps
`include "group_level_cfg.svh"

interface level_if;
    logic [`CODE_WIDTH-1:0]    code;
    logic [`CURRENT_WIDTH-1:0] current;

    modport owner   (output code, input current);
    modport decoder (input code, output current);
endinterface

// ---- level_decode.sv ----
// decodes a five-bit level code into a current in half-milliamp units
// assumes a purely combinational use; reserved codes give zero current
`timescale 1ns/100ps
`include "group_level_cfg.svh"

module level_decode
    import group_level_pkg::*;
(
    // level code in, current out
    level_if.decoder lvl
);

    level_code_t coarse;

    always_comb begin
        coarse = lvl.code - `COARSE_OFFSET;
        if (lvl.code < `CODE_FIRST_STEP) begin
            lvl.current = `CURRENT_ZERO;
        end else if (lvl.code <= `CODE_FINE_LAST) begin
            lvl.current = {1'b0, lvl.code - `FINE_OFFSET};
        end else if (lvl.code == `CODE_SIX_MA) begin
            lvl.current = `CURRENT_6_MA;
        end else if (lvl.code == `CODE_SEVEN_MA) begin
            lvl.current = `CURRENT_7_MA;
        end else if (lvl.code <= `CODE_COARSE_LAST) begin
            lvl.current = {coarse, 1'b0};
        end else if (lvl.code == `CODE_23_MA) begin
            lvl.current = `CURRENT_23_MA;
        end else begin
            lvl.current = `CURRENT_25_MA;
        end
    end

endmodule // level_decode

// ---- group_current_level_regs.sv ----
// second and third group current level registers with per-sink current drive
// assumes the pulse decoder, enable register and grouping logic share core_clk_i
`timescale 1ns/100ps
`include "group_level_cfg.svh"

// Contract
// - register 02h sets second group level
// - enabled second group sinks share one current
// - disabled sinks stay off whatever the code
// - bit D5 ignored, stored as zero
// - code zero gives zero, 1-3 reserved
// - codes 4-15 give 0.5 to 7 mA
// - codes 16-31 give 8 to 25 mA
// - register 03h sets third group level
// - third group low codes decode alike
// - both registers write-only, reset to zero
// - writes arrive from the pulse decoder
module group_current_level_regs
    import group_level_pkg::*;
(
    // clock and reset
    input  wire logic                          core_clk_i,
    input  wire logic                          reset_i,
    // register write from the pulse decoder
    input  wire logic                          wr_strobe_i,
    input  wire logic [`ADDR_WIDTH-1:0]        wr_addr_i,
    input  wire logic [`DATA_WIDTH-1:0]        wr_data_i,
    // sink enables and group membership
    input  wire logic [`SINK_COUNT-1:0]        sink_on_bits_i,
    input  wire logic [`SINK_COUNT-1:0]        second_member_i,
    input  wire logic [`SINK_COUNT-1:0]        third_member_i,
    // level codes and sink drive
    output logic      [`CODE_WIDTH-1:0]        second_level_o,
    output logic      [`CODE_WIDTH-1:0]        third_level_o,
    output logic      [`SINK_COUNT-1:0]        sink_active_o,
    output half_ma_t  [`SINK_COUNT-1:0]        sink_current_o
);

    level_state_t              state;
    level_state_t              next_state;
    level_if                   second_lvl ();
    level_if                   third_lvl ();
    logic [`SINK_COUNT-1:0]    next_act;
    half_ma_t [`SINK_COUNT-1:0] next_cur;

    assign second_lvl.code = state.second_code;
    assign third_lvl.code  = state.third_code;

    // second group decoder
    level_decode second_dec (
        .lvl (second_lvl.decoder)
    );

    level_decode third_dec (
        .lvl (third_lvl.decoder)
    );

    // per-sink drive selection
    for (genvar s = 0; s < `SINK_COUNT; s++) begin : g_sink
        always_comb begin
            if (!sink_on_bits_i[s]) begin
                next_act[s] = 1'b0;
                next_cur[s] = `CURRENT_ZERO;
            end else if (second_member_i[s]) begin
                next_act[s] = (second_lvl.current != `CURRENT_ZERO);
                next_cur[s] = second_lvl.current;
            end else if (third_member_i[s]) begin
                next_act[s] = (third_lvl.current != `CURRENT_ZERO);
                next_cur[s] = third_lvl.current;
            end else begin
                next_act[s] = 1'b0;
                next_cur[s] = `CURRENT_ZERO;
            end
        end
    end

    always_comb begin
        next_state          = state;
        next_state.sink_act = next_act;
        next_state.sink_cur = next_cur;
        if (wr_strobe_i) begin
            case (wr_addr_i)
                `SECOND_LEVEL_ADDR: begin
                    next_state.second_code = wr_data_i[`CODE_MSB:0];
                end
                `THIRD_LEVEL_ADDR: begin
                    next_state.third_code = wr_data_i[`CODE_MSB:0];
                end
                default: begin
                    next_state.second_code = state.second_code;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state.second_code <= `LEVEL_RESET;
            state.third_code  <= `LEVEL_RESET;
            state.sink_act    <= '0;
            state.sink_cur    <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign second_level_o = state.second_code;
    assign third_level_o  = state.third_code;
    assign sink_active_o  = state.sink_act;
    assign sink_current_o = state.sink_cur;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);

    // reset clears both levels
    reset_zero_a: assert property (
        $past(reset_i) |-> (second_level_o == `LEVEL_RESET) && (third_level_o == `LEVEL_RESET))
        else $error("levels not zero after reset");

    // second register takes written code
    second_write_a: assert property (
        wr_strobe_i && (wr_addr_i == `SECOND_LEVEL_ADDR)
        |=> second_level_o == $past(wr_data_i[`CODE_MSB:0]))
        else $error("second level not written");

    // third register takes written code
    third_write_a: assert property (
        wr_strobe_i && (wr_addr_i == `THIRD_LEVEL_ADDR)
        |=> third_level_o == $past(wr_data_i[`CODE_MSB:0]))
        else $error("third level not written");

    // other addresses leave levels alone
    other_addr_a: assert property (
        !(wr_strobe_i && ((wr_addr_i == `SECOND_LEVEL_ADDR) || (wr_addr_i == `THIRD_LEVEL_ADDR)))
        |=> $stable(second_level_o) && $stable(third_level_o))
        else $error("level changed without its write");

    // D5 has no effect
    top_bit_a: assert property (
        wr_strobe_i && (wr_addr_i == `SECOND_LEVEL_ADDR) && wr_data_i[`DATA_WIDTH-1]
        |=> second_level_o == $past(wr_data_i[`CODE_MSB:0]))
        else $error("bit D5 leaked into level");

    // disabled sinks stay off
    sink_off_a: assert property (
        !sink_on_bits_i[0] |=> !sink_active_o[0] && (sink_current_o[0] == `CURRENT_ZERO))
        else $error("disabled sink driven");

    // second group sinks share current
    second_share_a: assert property (
        (sink_on_bits_i[0] && second_member_i[0] && sink_on_bits_i[1] && second_member_i[1])
        ##1 $stable(second_level_o) |-> sink_current_o[0] == sink_current_o[1])
        else $error("second group currents differ");

    // reserved and zero codes give nothing
    low_code_a: assert property (
        (second_level_o < `CODE_FIRST_STEP) && sink_on_bits_i[0] && second_member_i[0]
        |=> sink_current_o[0] == `CURRENT_ZERO)
        else $error("low code drove current");

    // last fine step decodes exactly
    fine_step_a: assert property (
        (second_level_o == `CODE_FINE_LAST) && sink_on_bits_i[0] && second_member_i[0]
        |=> sink_current_o[0] == 6'h0a)
        else $error("5 mA code misdecoded");

    // top code gives 25 mA
    top_code_a: assert property (
        (second_level_o == `CODE_25_MA) && sink_on_bits_i[0] && second_member_i[0]
        |=> sink_current_o[0] == `CURRENT_25_MA)
        else $error("25 mA code misdecoded");

    // third group matches second decode
    third_match_a: assert property (
        (third_level_o == second_level_o) && sink_on_bits_i[2] && third_member_i[2]
        && sink_on_bits_i[0] && second_member_i[0] && !second_member_i[2]
        |=> sink_current_o[2] == sink_current_o[0])
        else $error("third decode differs");

    // third group 23 mA code
    third_top_a: assert property (
        (third_level_o == `CODE_23_MA) && sink_on_bits_i[4] && third_member_i[4] && !second_member_i[4]
        |=> sink_current_o[4] == `CURRENT_23_MA)
        else $error("23 mA third code misdecoded");

    // third group low codes give nothing
    third_low_a: assert property (
        (third_level_o < `CODE_FIRST_STEP) && sink_on_bits_i[2] && third_member_i[2] && !second_member_i[2]
        |=> sink_current_o[2] == `CURRENT_ZERO)
        else $error("third low code drove current");

    // third group six milliamp code
    third_six_a: assert property (
        (third_level_o == `CODE_SIX_MA) && sink_on_bits_i[2] && third_member_i[2] && !second_member_i[2]
        |=> sink_current_o[2] == `CURRENT_6_MA)
        else $error("6 mA third code misdecoded");

    // seven milliamp code
    seven_ma_a: assert property (
        (second_level_o == `CODE_SEVEN_MA) && sink_on_bits_i[0] && second_member_i[0]
        |=> sink_current_o[0] == `CURRENT_7_MA)
        else $error("7 mA code misdecoded");

    // first coarse step
    eight_ma_a: assert property (
        (second_level_o == 5'h10) && sink_on_bits_i[0] && second_member_i[0]
        |=> sink_current_o[0] == 6'h10)
        else $error("8 mA code misdecoded");

    // ungrouped sinks stay off
    no_group_a: assert property (
        sink_on_bits_i[3] && !second_member_i[3] && !third_member_i[3]
        |=> !sink_active_o[3] && (sink_current_o[3] == `CURRENT_ZERO))
        else $error("ungrouped sink driven");

    second_full_c: cover property (
        wr_strobe_i && (wr_addr_i == `SECOND_LEVEL_ADDR) && (wr_data_i[`CODE_MSB:0] == `CODE_25_MA));
    third_write_c: cover property (
        wr_strobe_i && (wr_addr_i == `THIRD_LEVEL_ADDR) ##2 (sink_active_o != '0));
    sink_off_c: cover property (
        (sink_active_o != '0) ##1 (sink_active_o == '0));
    reserved_c: cover property (
        wr_strobe_i && (wr_addr_i == `SECOND_LEVEL_ADDR) && (wr_data_i[`CODE_MSB:0] == 5'h02));

endmodule // group_current_level_regs

// ---- host_model.sv ----
// host side model issuing level register writes
// assumes the device samples writes on the rising edge of core_clk_i
`timescale 1ns/100ps
`include "group_level_cfg.svh"

module host_model (
    // clock
    input  wire logic              core_clk_i,
    // register write toward the device
    output logic                   wr_strobe_o,
    output logic [`ADDR_WIDTH-1:0] wr_addr_o,
    output logic [`DATA_WIDTH-1:0] wr_data_o
);
    initial begin
        wr_strobe_o = 1'b0;
        wr_addr_o   = 8'h00;
        wr_data_o   = 6'h00;
    end

    task automatic write(input logic [`ADDR_WIDTH-1:0] addr, input logic [`DATA_WIDTH-1:0] data);
        @(posedge core_clk_i);
        #1;
        wr_strobe_o = 1'b1;
        wr_addr_o   = addr;
        wr_data_o   = data;
        @(posedge core_clk_i);
        #1;
        wr_strobe_o = 1'b0;
        wr_addr_o   = ~addr;
        wr_data_o   = ~data;
    endtask
endmodule // host_model

// ---- tb_group_current_level_regs.sv ----
// testbench of the second and third group current level registers
// assumes host_model drives the write port and sink inputs are static levels
`timescale 1ns/100ps
`include "group_level_cfg.svh"

module tb_group_current_level_regs;
    import group_level_pkg::*;

    logic                       core_clk_i;
    logic                       reset_i;
    logic                       wr_strobe;
    logic [`ADDR_WIDTH-1:0]     wr_addr;
    logic [`DATA_WIDTH-1:0]     wr_data;
    logic [`SINK_COUNT-1:0]     sink_on_bits;
    logic [`SINK_COUNT-1:0]     second_member;
    logic [`SINK_COUNT-1:0]     third_member;
    logic [`CODE_WIDTH-1:0]     second_level;
    logic [`CODE_WIDTH-1:0]     third_level;
    logic [`SINK_COUNT-1:0]     sink_active;
    half_ma_t [`SINK_COUNT-1:0] sink_current;
    int                         failures;
    int                         checks;

    always #2 core_clk_i = ~core_clk_i;

    host_model u_host_model (
        .core_clk_i  (core_clk_i),
        .wr_strobe_o (wr_strobe),
        .wr_addr_o   (wr_addr),
        .wr_data_o   (wr_data)
    );

    group_current_level_regs u_group_current_level_regs (
        .core_clk_i      (core_clk_i),
        .reset_i         (reset_i),
        .wr_strobe_i     (wr_strobe),
        .wr_addr_i       (wr_addr),
        .wr_data_i       (wr_data),
        .sink_on_bits_i  (sink_on_bits),
        .second_member_i (second_member),
        .third_member_i  (third_member),
        .second_level_o  (second_level),
        .third_level_o   (third_level),
        .sink_active_o   (sink_active),
        .sink_current_o  (sink_current)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // current in half milliamps for a level code
    function automatic logic [7:0] exp_cur(input int code);
        if (code < 4) return 8'h00;
        if (code <= 13) return 8'(code - 3);
        if (code == 14) return 8'h0c;
        if (code == 15) return 8'h0e;
        if (code <= 29) return 8'(2 * (code - 8));
        return (code == 30) ? 8'h2e : 8'h32;
    endfunction

    task automatic settle();
        @(posedge core_clk_i);
        #1;
    endtask

    task automatic reset_values();
        check({3'h0, second_level}, 8'h00, "second reset");
        check({3'h0, third_level}, 8'h00, "third reset");
        check({3'h0, sink_active}, 8'h00, "active reset");
        check({2'h0, sink_current[1]}, 8'h00, "current reset");
    endtask

    task automatic sweep(input logic [7:0] addr, input int sa, input int sb);
        for (int c = 0; c < 32; c++) begin
            if (c == 0 || c > 3) begin
                u_host_model.write(addr, 6'(c));
                check({3'h0, addr == 8'h02 ? second_level : third_level}, 8'(c), "level");
                settle();
                check({2'h0, sink_current[sa]}, exp_cur(c), "current");
                check({2'h0, sink_current[sb]}, exp_cur(c), "shared current");
                check({7'h0, sink_active[sa]}, {7'h0, c > 3}, "active");
            end
        end
    endtask

    task automatic d5_and_unmapped();
        u_host_model.write(8'h02, 6'h25);
        check({3'h0, second_level}, 8'h05, "d5 dropped");
        u_host_model.write(8'h04, 6'h0a);
        check({3'h0, second_level}, 8'h05, "unmapped second");
        check({3'h0, third_level}, 8'h1f, "unmapped third");
    endtask

    task automatic disabled_sink();
        sink_on_bits = 5'h1e;
        settle();
        settle();
        check({2'h0, sink_current[0]}, 8'h00, "disabled current");
        check({7'h0, sink_active[0]}, 8'h00, "disabled active");
        check({2'h0, sink_current[1]}, exp_cur(5), "enabled current");
        check({2'h0, sink_current[3]}, 8'h00, "no group");
    endtask

    task automatic summarize();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        core_clk_i    = 1'b0;
        reset_i       = 1'b1;
        sink_on_bits  = 5'h1f;
        second_member = 5'h03;
        third_member  = 5'h14;
        failures      = 0;
        checks        = 0;
        repeat (2) @(posedge core_clk_i);
        #1;
        reset_i = 1'b0;
        reset_values();
        sweep(8'h02, 0, 1);
        check({3'h0, third_level}, 8'h00, "third untouched");
        sweep(8'h03, 2, 4);
        d5_and_unmapped();
        disabled_sink();
        summarize();
    end
endmodule // tb_group_current_level_regs
